// ### shared/dcc_pkg.sv
// Behaviour
// R1 - Gate bit disables matching port-0 input
// R2 - Gated port-0 bits read back as zero
// R3 - Result high when positive exceeds negative
// R4 - Positive from two pins, negative pin/reference
// R5 - Select and output bits give eight configurations
// R6 - Result readable, drives pin when enabled
// R7 - Two control registers with identical layout
// R8 - Software waits 10 us before interrupt
// R9 - Software clears flag before enabling interrupt
// R10 - Result change sets the change flag
// R11 - Request needs flag, own and global enable; irq_out needs only a status bit and its mask bit
// R12 - Comparators keep running in idle/power-down
// R13 - Enabled change wakes processor from sleep
// R14 - Software makes output pin push-pull
// R15 - Software makes analog pins input-only
// R16 - Internal reference is default negative input
// R17 - Service routine clears flag before return
// R18 - Synchronise result, detect change against previous
package dcc_pkg;
    // Register indices; byte address is four times the index
    localparam int          IDX_W       = 10;
    localparam logic [9:0]  GATE_IDX    = 10'h0f6;
    localparam logic [1:0][9:0] CTL_IDX = {10'h0f1, 10'h0f0};
    localparam logic [9:0]  IEN_IDX     = 10'h0f2;
    localparam logic [9:0]  STS_IDX     = 10'h0f3;
    localparam logic [9:0]  MSK_IDX     = 10'h0f4;
    localparam logic [9:0]  PORT_IDX    = 10'h0f5;
    // Comparator control register fields
    localparam int          FLAG_B      = 0;
    localparam int          OE_B        = 1;
    localparam int          CN_B        = 2;
    localparam int          CP_B        = 3;
    localparam int          RES_B       = 4;
    localparam int          EN_B        = 5;
    localparam int          CTL_W       = 6;
    // Interrupt enable register fields
    localparam logic [1:0][2:0] EC_B    = {3'h2, 3'h5};
    localparam int          EA_B        = 7;
    // Reset values
    localparam logic [7:0]  GATE_RST    = 8'h00;
    localparam logic [7:0]  IEN_RST     = 8'h00;
    localparam logic [5:0]  CTL_RST     = 6'h00;
    localparam logic [1:0]  STS_RST     = 2'h0;
    localparam logic [1:0]  MSK_RST     = 2'h0;
    // Analog level coding and internal reference code
    localparam int          AIN_W       = 8;
    localparam logic [7:0]  VREF_CODE   = 8'h41;
endpackage

// ### shared/dcc_chan_if.sv
interface dcc_chan_if #(parameter int AW = 8);
    logic          en;
    logic          cp;
    logic          cn;
    logic [AW-1:0] pos_a;
    logic [AW-1:0] pos_b;
    logic [AW-1:0] neg_pin;
    logic [AW-1:0] vref;
    logic          result;
    logic          change;
    modport ctl (output en, cp, cn, pos_a, pos_b, neg_pin, vref,
                 input  result, change);
    modport cmp (input  en, cp, cn, pos_a, pos_b, neg_pin, vref,
                 output result, change);
endinterface

// ### hdl/dcc_cmp_chan.sv
module dcc_cmp_chan (
    input  wire logic sys_clk_in,
    input  wire logic rstn_in,
    dcc_chan_if.cmp   ch
);
    import dcc_pkg::*;

    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic chg;
    } dcc_chan_s;

    dcc_chan_s st_r;
    dcc_chan_s st_nxt;
    logic      raw_w;

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [$bits(ch.pos_a)-1:0] pos;
        logic [$bits(ch.pos_a)-1:0] neg;
        // R4 input selection
        pos = ch.cp ? ch.pos_b : ch.pos_a;
        // R16 reference by default
        neg = ch.cn ? ch.neg_pin : ch.vref;
        // R3 positive above negative
        raw_w = ch.en && (pos > neg);
        st_nxt = st_r;
        st_nxt.s1 = raw_w;
        st_nxt.s2 = st_r.s1;
        st_nxt.prev = st_r.s2;
        // R18 compare with previous
        st_nxt.chg = ch.en && (st_r.s2 != st_r.prev);
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign ch.result = st_r.s2;
    assign ch.change = st_r.chg;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    a_result_delay: assert property ( // R3
        ch.result == $past(raw_w, 2))
        else $error("result not raw comparison two cycles late");
    a_change_pulse: assert property ( // R18
        (ch.en && $changed(ch.result)) |=> ch.change)
        else $error("result change gave no change pulse");
    a_no_false_chg: assert property ( // R18
        $stable(st_r.s2) ##1 $stable(st_r.s2) |=> !ch.change)
        else $error("change pulse without result change");
endmodule // dcc_cmp_chan

// ### hdl/dcc_top.sv
module dcc_top #(
    parameter int              AW   = dcc_pkg::AIN_W,
    parameter logic [AW-1:0]   VREF = AW'(dcc_pkg::VREF_CODE)
) (
    input  wire logic               sys_clk_in,
    input  wire logic               rstn_in,
    input  wire logic               wb_cyc_in,
    input  wire logic               wb_stb_in,
    input  wire logic               wb_we_in,
    input  wire logic [11:0]        wb_adr_in,
    input  wire logic [3:0]         wb_sel_in,
    input  wire logic [31:0]        wb_dat_in,
    output      logic [31:0]        wb_dat_out,
    output      logic               wb_ack_out,
    input  wire logic [1:0][AW-1:0] pos_a_in,
    input  wire logic [1:0][AW-1:0] pos_b_in,
    input  wire logic [1:0][AW-1:0] neg_pin_in,
    input  wire logic [7:0]         port0_pins_in,
    input  wire logic               idle_in,
    input  wire logic               pdown_in,
    output      logic [1:0]         cmp_pin_out,
    output      logic [1:0]         cmp_pin_oe_out,
    output      logic [7:0]         port0_din_dis_out,
    output      logic [1:0]         cmp_irq_out,
    output      logic               irq_out,
    output      logic               wake_out
);
    import dcc_pkg::*;

    typedef struct packed {
        logic [1:0][CTL_W-1:0] ctl;
        logic [7:0]            ien;
        logic [1:0]            sts;
        logic [1:0]            msk;
        logic [7:0]            gate;
        logic                  ack;
        logic [31:0]           rdat;
        logic [1:0]            pin;
        logic [1:0]            pin_oe;
        logic [1:0]            cmp_irq;
        logic                  irq;
        logic                  wake;
    } dcc_st_s;

    localparam dcc_st_s ST_RST = '{
        ctl: {CTL_RST, CTL_RST}, ien: IEN_RST, sts: STS_RST,
        msk: MSK_RST, gate: GATE_RST, default: '0};

    dcc_st_s    st_r;
    dcc_st_s    st_nxt;
    logic [1:0] res_w;
    logic [1:0] chg_w;

    ////////////////////////////////////////////////////////////////////
    // One comparator channel per control register
    // R7 identical channels
    for (genvar i = 0; i < 2; i++) begin : g_cmp
        dcc_chan_if #(.AW(AW)) ch ();
        assign ch.en      = st_r.ctl[i][EN_B];
        assign ch.cp      = st_r.ctl[i][CP_B];
        assign ch.cn      = st_r.ctl[i][CN_B];
        assign ch.pos_a   = pos_a_in[i];
        assign ch.pos_b   = pos_b_in[i];
        assign ch.neg_pin = neg_pin_in[i];
        assign ch.vref    = VREF;
        assign res_w[i]   = ch.result;
        assign chg_w[i]   = ch.change;
        // R12 no power-mode gating
        dcc_cmp_chan u_chan (
            .sys_clk_in (sys_clk_in),
            .rstn_in    (rstn_in),
            .ch         (ch.cmp)
        );
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        logic             acc;
        logic             wr;
        logic [IDX_W-1:0] idx;
        logic [7:0]       d;
        acc = wb_cyc_in && wb_stb_in && !st_r.ack;
        wr  = acc && wb_we_in && wb_sel_in[0];
        idx = wb_adr_in[11:2];
        d   = wb_dat_in[7:0];
        st_nxt = st_r;
        st_nxt.ack = acc;

        for (int i = 0; i < 2; i++) begin
            if (wr && idx == CTL_IDX[i]) begin
                // R5 eight configurations
                st_nxt.ctl[i][EN_B] = d[EN_B];
                st_nxt.ctl[i][CP_B] = d[CP_B];
                st_nxt.ctl[i][CN_B] = d[CN_B];
                st_nxt.ctl[i][OE_B] = d[OE_B];
                if (!d[FLAG_B]) begin
                    st_nxt.ctl[i][FLAG_B] = 1'b0;
                end
            end
            // R10 change sets flag
            if (chg_w[i]) begin
                st_nxt.ctl[i][FLAG_B] = 1'b1;
            end
            st_nxt.ctl[i][RES_B] = res_w[i];
            // R6 result onto pin
            st_nxt.pin[i]    = res_w[i];
            st_nxt.pin_oe[i] = st_r.ctl[i][OE_B];
            // R11 three-way gate
            st_nxt.cmp_irq[i] = st_r.ctl[i][FLAG_B]
                              && st_r.ien[EC_B[i]] && st_r.ien[EA_B];
        end

        if (wr && idx == STS_IDX) begin
            st_nxt.sts = st_r.sts & ~d[1:0];
        end
        st_nxt.sts = st_nxt.sts | chg_w;
        if (wr && idx == MSK_IDX) begin
            st_nxt.msk = d[1:0];
        end
        if (wr && idx == IEN_IDX) begin
            st_nxt.ien = d;
        end
        // R1 gate register
        if (wr && idx == GATE_IDX) begin
            st_nxt.gate = d;
        end

        st_nxt.irq = |(st_r.sts & st_r.msk);
        // R13 wake on enabled change
        st_nxt.wake = (|st_r.cmp_irq) && (idle_in || pdown_in);

        st_nxt.rdat = '0;
        if (acc && !wb_we_in) begin
            unique case (idx)
                CTL_IDX[0]: st_nxt.rdat[7:0] = {2'h0, st_r.ctl[0]};
                CTL_IDX[1]: st_nxt.rdat[7:0] = {2'h0, st_r.ctl[1]};
                IEN_IDX:    st_nxt.rdat[7:0] = st_r.ien;
                STS_IDX:    st_nxt.rdat[1:0] = st_r.sts;
                MSK_IDX:    st_nxt.rdat[1:0] = st_r.msk;
                GATE_IDX:   st_nxt.rdat[7:0] = st_r.gate;
                // R2 gated bits read zero
                PORT_IDX:   st_nxt.rdat[7:0] = port0_pins_in & ~st_r.gate;
                default:    st_nxt.rdat = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_out        = st_r.rdat;
    assign wb_ack_out        = st_r.ack;
    assign cmp_pin_out       = st_r.pin;
    assign cmp_pin_oe_out    = st_r.pin_oe;
    assign port0_din_dis_out = st_r.gate;
    assign cmp_irq_out       = st_r.cmp_irq;
    assign irq_out           = st_r.irq;
    assign wake_out          = st_r.wake;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_req;
        wb_cyc_in && wb_stb_in && !wb_ack_out;
    endsequence
    sequence s_ack_once;
        wb_ack_out ##1 !wb_ack_out;
    endsequence

    a_bus_ack_once: assert property (
        s_req |=> s_ack_once)
        else $error("bus request not answered once next cycle");
    a_port_gated: assert property ( // R2
        (s_req ##0 !wb_we_in && wb_adr_in[11:2] == PORT_IDX)
        |=> (wb_dat_out[7:0] & port0_din_dis_out) == 8'h00)
        else $error("gated port bit read as one");
    a_gate_written: assert property ( // R1
        (s_req ##0 wb_we_in && wb_sel_in[0]
         && wb_adr_in[11:2] == GATE_IDX)
        |=> port0_din_dis_out == $past(wb_dat_in[7:0]))
        else $error("gate register write not applied");
    a_flag_on_chg: assert property ( // R10
        chg_w[0] |=> st_r.ctl[0][FLAG_B])
        else $error("change did not set flag");
    a_sts_set_wins: assert property ( // R10
        chg_w[1] |=> st_r.sts[1])
        else $error("status clear beat a new change");
    a_irq_gate: assert property ( // R11
        cmp_irq_out[0] |-> $past(st_r.ctl[0][FLAG_B])
        && $past(st_r.ien[EA_B]) && $past(st_r.ien[EC_B[0]]))
        else $error("request without flag and both enables");
    a_pin_follow: assert property ( // R6
        cmp_pin_out == $past(res_w)
        && cmp_pin_oe_out == {$past(st_r.ctl[1][OE_B]),
                              $past(st_r.ctl[0][OE_B])})
        else $error("pin does not follow result or enable");
    a_wake_sleep: assert property ( // R13
        (|cmp_irq_out && (idle_in || pdown_in)) |=> wake_out)
        else $error("enabled change did not wake processor");
    a_irq_level: assert property (
        irq_out == $past(|(st_r.sts & st_r.msk)))
        else $error("interrupt output not masked status");
endmodule // dcc_top

// ### testbench/dcc_ana_model.sv
module dcc_ana_model (
    input  wire logic            clk_in,
    output      logic [1:0][7:0] pos_a_out,
    output      logic [1:0][7:0] pos_b_out,
    output      logic [1:0][7:0] neg_pin_out
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        pos_a_out   = '0;
        pos_b_out   = '0;
        neg_pin_out = '0;
    end

    // input-only analog pins
    // Analog levels move only just after a clock edge
    task automatic drive(input int c, input logic [7:0] a, b, n);
        @(posedge clk_in);
        pos_a_out[c]   <= a;
        pos_b_out[c]   <= b;
        neg_pin_out[c] <= n;
    endtask
endmodule // dcc_ana_model

// ### testbench/dcc_top_tb_top.sv
module dcc_top_tb_top;
    import dcc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic                clk = 1'b0;
    logic                rstn = 1'b0;
    logic                cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [11:0]         adr = '0;
    logic [3:0]          sel = '0;
    logic [31:0]         dat = '0;
    logic [31:0]         rdat;
    logic                ack, irq, wake;
    logic [1:0][7:0]     pa, pb, pn;
    logic [7:0]          pins = '0, dis, g, p, a, b, n;
    logic                idle = 1'b0, pdown = 1'b0, res;
    logic [1:0]          cpin, coe, cirq;
    logic [5:0]          cfg;
    logic [31:0]         q[$];
    logic [9:0]          ridx[7];
    int                  errors = 0, n_compared = 0, seed = 32'h45f1f0b9;

    always #5 clk = ~clk;

    dcc_ana_model ana (.clk_in(clk), .pos_a_out(pa), .pos_b_out(pb),
                       .neg_pin_out(pn));

    dcc_top uut (.sys_clk_in(clk), .rstn_in(rstn), .wb_cyc_in(cyc),
        .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel),
        .wb_dat_in(dat), .wb_dat_out(rdat), .wb_ack_out(ack),
        .pos_a_in(pa), .pos_b_in(pb), .neg_pin_in(pn),
        .port0_pins_in(pins), .idle_in(idle), .pdown_in(pdown),
        .cmp_pin_out(cpin), .cmp_pin_oe_out(coe),
        .port0_din_dis_out(dis), .cmp_irq_out(cirq), .irq_out(irq),
        .wake_out(wake));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (errors == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Classic cycle: request held up to the rising edge that samples ack
    task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] d,
                      input logic s);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {i, 2'h0};
        dat <= {24'h0, d};
        sel <= {3'h0, s};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        wb(1'b1, i, d, 1'b1);
    endtask

    task automatic rd(input logic [9:0] i, input logic [31:0] e);
        q.push_back(e);
        wb(1'b0, i, 8'h0, 1'b1);
    endtask

    task automatic settle(input int c);
        repeat (c) @(posedge clk);
        @(negedge clk);
    endtask

    // Read data is taken at the rising edge that samples ack high
    always @(posedge clk)
        if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0)
            chk(rdat, q.size() > 0 ? q.pop_front() : 32'hxxxxxxxx);

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        tally_and_finish();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        ridx = '{GATE_IDX, CTL_IDX[0], CTL_IDX[1], IEN_IDX, STS_IDX,
                 MSK_IDX, 10'h100};
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        foreach (ridx[i])
            rd(ridx[i], 32'h0);
        g = 8'($random(seed));
        p = 8'($random(seed));
        pins <= p;
        wr(GATE_IDX, g);
        rd(GATE_IDX, {24'h0, g});
        rd(PORT_IDX, {24'h0, p & ~g});
        wb(1'b1, GATE_IDX, ~g, 1'b0);
        wr(10'h100, 8'hff);
        rd(GATE_IDX, {24'h0, g});
        rd(10'h100, 32'h0);
        settle(1);
        chk(dis, g);
        for (int c = 0; c < 2; c++)
            for (int k = 0; k < 8; k++) begin
                a = 8'($random(seed));
                b = 8'($random(seed));
                n = 8'($random(seed));
                ana.drive(c, a, b, n);
                cfg = {2'h2, k[2:0], 1'h0};
                wr(CTL_IDX[c], {2'h0, cfg});
                settle(8);
                wr(CTL_IDX[c], {2'h0, cfg});
                settle(3);
                res = (k[2] ? b : a) > (k[1] ? n : VREF_CODE);
                rd(CTL_IDX[c], {26'h0, cfg} | {27'h0, res, 4'h0});
                chk({coe[c], coe[c] & cpin[c]}, {k[0], k[0] & res});
            end
        ana.drive(0, 8'h10, 8'h00, 8'h20);
        wr(CTL_IDX[0], 8'h26);
        repeat (1000) @(posedge clk);
        wr(CTL_IDX[0], 8'h26);
        wr(STS_IDX, 8'h03);
        wr(MSK_IDX, 8'h01);
        wr(IEN_IDX, (8'h1 << EC_B[0]) | (8'h1 << EA_B));
        idle  <= 1'b1;
        pdown <= 1'($random(seed));
        settle(3);
        chk({wake, irq, cirq}, 32'h0);
        ana.drive(0, 8'h30, 8'h00, 8'h20);
        settle(8);
        chk({wake, irq, cirq}, 32'hd);
        chk({coe[0], cpin[0]}, 32'h3);
        rd(CTL_IDX[0], 32'h37);
        rd(STS_IDX, 32'h1);
        wr(IEN_IDX, 8'h1 << EC_B[0]);
        settle(3);
        chk({wake, irq, cirq}, 32'h4);
        wr(MSK_IDX, 8'h00);
        settle(3);
        chk({wake, irq, cirq}, 32'h0);
        wr(CTL_IDX[0], 8'h26);
        wr(STS_IDX, 8'h01);
        rd(CTL_IDX[0], 32'h36);
        rd(STS_IDX, 32'h0);
        settle(2);
        tally_and_finish();
    end
endmodule // dcc_top_tb_top
